// ==== rtl/cwc_pkg.sv ====
// Purpose: shared constants and types for the cluster wakeup control block
// Assumes: 125 MHz MCLK, AHB-Lite register access, 32-bit data
// Notes: offsets are byte addresses of word registers
package cwc_pkg;
  localparam int unsigned CWC_CLK_MHZ = 125;
  // default timer lengths in microseconds, converted to cycles below
  localparam int unsigned CWC_FAST_US = 100;
  localparam int unsigned CWC_NOISE_US = 1000;
  localparam int unsigned CWC_FAST_CYC = CWC_FAST_US * CWC_CLK_MHZ;
  localparam int unsigned CWC_NOISE_CYC = CWC_NOISE_US * CWC_CLK_MHZ;
  localparam int unsigned CWC_TMR_W = 24;
  // pattern symbol timing in cycles: driven part then idle part
  localparam int unsigned CWC_SYM_TX_CYC = 64;
  localparam int unsigned CWC_SYM_IDLE_CYC = 32;
  localparam int unsigned CWC_SYM_W = 8;
  localparam logic [3:0] CWC_REPEAT_MIN = 4'h2;
  localparam logic [3:0] CWC_REPEAT_RST = 4'h2;

  // register byte offsets
  localparam logic [7:0] CWC_OFF_CFG = 8'h00;
  localparam logic [7:0] CWC_OFF_CMD = 8'h04;
  localparam logic [7:0] CWC_OFF_STAT = 8'h08;
  // configuration fields
  localparam int unsigned CWC_CFG_CHAN_BIT = 0;
  localparam int unsigned CWC_CFG_REP_LSB = 4;
  localparam int unsigned CWC_CFG_REP_MSB = 7;
  // command codes written to the command register
  localparam logic [3:0] CWC_CMD_CONFIG = 4'h1;
  localparam logic [3:0] CWC_CMD_CONFIG_DONE = 4'h2;
  localparam logic [3:0] CWC_CMD_WAKEUP = 4'h3;
  localparam logic [3:0] CWC_CMD_READY_NOW = 4'h4;
  localparam logic [3:0] CWC_CMD_READY_LATER = 4'h5;
  localparam logic [3:0] CWC_CMD_HALT_LATER = 4'h6;
  localparam logic [3:0] CWC_CMD_FREEZE = 4'h7;
  localparam logic [3:0] CWC_CMD_DEFAULT = 4'h8;
  // status fields
  localparam int unsigned CWC_ST_RES_LSB = 0;
  localparam int unsigned CWC_ST_STATE_LSB = 8;

  typedef enum logic [2:0] {
    CWC_RES_NOT_SET = 3'h0,
    CWC_RES_HEADER_HEARD = 3'h1,
    CWC_RES_PATTERN_HEARD = 3'h2,
    CWC_RES_CLASH_HEADER = 3'h3,
    CWC_RES_CLASH_PATTERN = 3'h4,
    CWC_RES_CLASH_UNCLASSIFIED = 3'h5,
    CWC_RES_TRANSMITTED = 3'h6
  } cwc_result_e;

  typedef enum logic [6:0] {
    CWC_ST_DEFAULT_CFG = 7'h01,
    CWC_ST_CONFIG = 7'h02,
    CWC_ST_READY = 7'h04,
    CWC_ST_LISTEN = 7'h08,
    CWC_ST_SEND = 7'h10,
    CWC_ST_DETECT = 7'h20,
    CWC_ST_HALT = 7'h40
  } cwc_state_e;
endpackage : cwc_pkg

// ==== rtl/cwc_timer.sv ====
// Purpose: loadable down-counter with expiry flag
// Assumes: single clock, synchronous active-low reset
// Notes: expired is high once the count reaches zero while running
`timescale 1ns/100ps
`default_nettype none
module cwc_timer #(
  parameter int unsigned W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] load_value,
  // status
  output logic expired
);
  logic [W-1:0] count_ff;
  logic run_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_ff <= '0;
      run_ff <= 1'b0;
    end else if (start) begin
      count_ff <= load_value;
      run_ff <= 1'b1;
    end else if (stop) begin
      run_ff <= 1'b0;
    end else if (run_ff && count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  assign expired = run_ff && (count_ff == '0);
endmodule : cwc_timer
`default_nettype wire

// ==== rtl/cwc_symbol_gen.sv ====
// Purpose: wakeup pattern sequencer, driven part then idle part per symbol
// Assumes: repeat count of at least two checked by the caller
// Notes: in_idle marks the listening window of each symbol
`timescale 1ns/100ps
`default_nettype none
module cwc_symbol_gen
  import cwc_pkg::*;
#(
  parameter int unsigned TX_CYC = CWC_SYM_TX_CYC,
  parameter int unsigned IDLE_CYC = CWC_SYM_IDLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] repeat_count,
  // status
  output logic drive_low,
  output logic in_idle,
  output logic done
);
  logic [CWC_SYM_W-1:0] phase_ff;
  logic [3:0] sym_left_ff;
  logic active_ff;
  logic idle_ff;
  logic done_ff;
  localparam logic [CWC_SYM_W-1:0] TX_LAST = CWC_SYM_W'(TX_CYC - 1);
  localparam logic [CWC_SYM_W-1:0] IDLE_LAST = CWC_SYM_W'(IDLE_CYC - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_ff <= '0;
      sym_left_ff <= 4'h0;
      active_ff <= 1'b0;
      idle_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        phase_ff <= '0;
        sym_left_ff <= repeat_count;
        active_ff <= 1'b1;
        idle_ff <= 1'b0;
      end else if (abort) begin
        active_ff <= 1'b0;
        idle_ff <= 1'b0;
      end else if (active_ff) begin
        if (!idle_ff && phase_ff == TX_LAST) begin
          phase_ff <= '0;
          idle_ff <= 1'b1;
        end else if (idle_ff && phase_ff == IDLE_LAST) begin
          phase_ff <= '0;
          idle_ff <= 1'b0;
          sym_left_ff <= sym_left_ff - 4'h1;
          if (sym_left_ff == 4'h1) begin
            active_ff <= 1'b0;
            done_ff <= 1'b1;
          end
        end else begin
          phase_ff <= phase_ff + 1'b1;
        end
      end
    end
  end

  assign drive_low = active_ff && !idle_ff;
  assign in_idle = active_ff && idle_ff;
  assign done = done_ff;
endmodule : cwc_symbol_gen
`default_nettype wire

// ==== rtl/cwc_wakeup_ctrl.sv ====
// Purpose: cluster wakeup sequence of the protocol operation control
// Assumes: AHB-Lite slave, bus events from decoders arrive as pins
// Notes: listen, send and detect phases, result code for the host
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - wakeup pattern goes out on exactly one channel, never both.
// - wakeup command in ready starts listen, then tries sending.
// - sequence end returns to ready and exposes the result.
// - result reads not-set before any command and while in progress.
// - aborts and repeat count below two leave the result not set.
// - clean header heard on any channel in listen gives header result.
// - pattern heard on wake channel in listen gives pattern result.
// - header in detect after collision gives header clash result.
// - pattern in detect after collision gives pattern clash result.
// - detect timeout without classification gives unclassified clash result.
// - full pattern sent without collision gives transmitted result.
// - header on any channel or pattern on wake channel in listen ends it without sending.
// - listen uses a fast timer and a noise-tolerant timer.
// - channel watched only in idle gaps; activity there goes to detect.
// - detect ends on fast timer or at once on header or pattern.
// - channels stuck active low keep the sequence until a host command.
// - ready-now command forces ready directly from any wakeup state.
module cwc_wakeup_ctrl
  import cwc_pkg::*;
#(
  parameter int unsigned FAST_CYC = CWC_FAST_CYC,
  parameter int unsigned NOISE_CYC = CWC_NOISE_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // channel receive events, per channel a and b
  input wire logic [1:0] RX_ACTIVE,
  input wire logic [1:0] RX_HEADER_OK,
  input wire logic [1:0] RX_PATTERN_OK,
  // channel transmit, per channel a and b
  output logic [1:0] TX_DATA,
  output logic [1:0] TX_ENABLE
);
  // synchronised receive inputs
  logic [5:0] rx_meta_ff;
  logic [5:0] rx_sync_ff;
  logic [1:0] rx_active;
  logic [1:0] rx_header;
  logic [1:0] rx_pattern;

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      rx_meta_ff <= 6'h00;
      rx_sync_ff <= 6'h00;
    end else begin
      rx_meta_ff <= {RX_PATTERN_OK, RX_HEADER_OK, RX_ACTIVE};
      rx_sync_ff <= rx_meta_ff;
    end
  end
  assign rx_active = rx_sync_ff[1:0];
  assign rx_header = rx_sync_ff[3:2];
  assign rx_pattern = rx_sync_ff[5:4];

  // register state
  cwc_state_e state_ff;
  cwc_state_e nxt_state;
  cwc_result_e result_ff;
  logic wake_channel_select_ff;
  logic [3:0] wake_pattern_repeat_count_ff;
  logic [3:0] cmd_ff;
  logic cmd_valid_ff;

  // ahb-lite address phase capture
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] addr_ff;
  logic [31:0] rdata_ff;
  logic take;

  assign take = HSEL && HREADY && HTRANS[1];

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= take && HWRITE;
      rd_pend_ff <= take && !HWRITE;
      if (take) begin
        addr_ff <= HADDR[7:0];
      end
    end
  end

  // zero wait states, always okay
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[CWC_ST_RES_LSB +: 3] = result_ff;
    status_word[CWC_ST_STATE_LSB +: 7] = state_ff;
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      rdata_ff <= 32'h0000_0000;
    end else if (take && !HWRITE) begin
      unique case (HADDR[7:0])
        CWC_OFF_CFG: begin
          rdata_ff <= {24'h00_0000, wake_pattern_repeat_count_ff, 3'h0,
                       wake_channel_select_ff};
        end
        CWC_OFF_STAT: rdata_ff <= status_word;
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign HRDATA = rdata_ff;

  // configuration writes accepted only in configuration state
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      wake_channel_select_ff <= 1'b0;
      wake_pattern_repeat_count_ff <= CWC_REPEAT_RST;
    end else if (wr_pend_ff && addr_ff == CWC_OFF_CFG && state_ff == CWC_ST_CONFIG) begin
      wake_channel_select_ff <= HWDATA[CWC_CFG_CHAN_BIT];
      wake_pattern_repeat_count_ff <= HWDATA[CWC_CFG_REP_MSB:CWC_CFG_REP_LSB];
    end
  end

  // command strobe, one cycle after the data phase
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      cmd_ff <= 4'h0;
      cmd_valid_ff <= 1'b0;
    end else begin
      cmd_valid_ff <= wr_pend_ff && addr_ff == CWC_OFF_CMD;
      cmd_ff <= HWDATA[3:0];
    end
  end

  logic cmd_wakeup;
  logic cmd_abort;
  assign cmd_wakeup = cmd_valid_ff && cmd_ff == CWC_CMD_WAKEUP;
  assign cmd_abort = cmd_valid_ff && (cmd_ff == CWC_CMD_READY_NOW ||
                     cmd_ff == CWC_CMD_READY_LATER || cmd_ff == CWC_CMD_HALT_LATER ||
                     cmd_ff == CWC_CMD_FREEZE);

  // wake channel events
  logic ch;
  logic ch_active;
  logic any_header;
  logic ch_pattern;
  assign ch = wake_channel_select_ff;
  assign ch_active = rx_active[ch];
  assign any_header = |rx_header;
  assign ch_pattern = rx_pattern[ch];

  // timers
  logic fast_start;
  logic noise_start;
  logic fast_expired;
  logic noise_expired;
  logic in_wake;
  assign in_wake = state_ff == CWC_ST_LISTEN || state_ff == CWC_ST_SEND ||
                   state_ff == CWC_ST_DETECT;

  // fast timer restarts whenever the wake channel is busy in listen, noise timer only once it has expired
  assign fast_start = (nxt_state == CWC_ST_LISTEN && (state_ff != CWC_ST_LISTEN ||
                      ch_active)) || (nxt_state == CWC_ST_DETECT &&
                      state_ff != CWC_ST_DETECT);
  assign noise_start = nxt_state == CWC_ST_LISTEN && (state_ff != CWC_ST_LISTEN ||
                       (ch_active && noise_expired));

  cwc_timer #(
    .W(CWC_TMR_W)
  ) u_fast (
    .clk(MCLK),
    .rst_n(RESET_N),
    .start(fast_start),
    .stop(!in_wake),
    .load_value(CWC_TMR_W'(FAST_CYC)),
    .expired(fast_expired)
  );

  cwc_timer #(
    .W(CWC_TMR_W)
  ) u_noise (
    .clk(MCLK),
    .rst_n(RESET_N),
    .start(noise_start),
    .stop(state_ff != CWC_ST_LISTEN),
    .load_value(CWC_TMR_W'(NOISE_CYC)),
    .expired(noise_expired)
  );

  // pattern generator
  logic sym_start;
  logic sym_drive;
  logic sym_idle;
  logic sym_done;
  logic collision;
  logic [1:0] idle_seen_ff;
  assign sym_start = state_ff == CWC_ST_LISTEN && nxt_state == CWC_ST_SEND;

  // our own driven part echoes back through the two receive flops, so the first
  // two idle cycles are blanked; activity within those two cycles goes unseen
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      idle_seen_ff <= 2'b00;
    end else begin
      idle_seen_ff <= {idle_seen_ff[0], sym_idle};
    end
  end
  assign collision = state_ff == CWC_ST_SEND && sym_idle && idle_seen_ff[1] &&
                     ch_active;

  cwc_symbol_gen u_sym (
    .clk(MCLK),
    .rst_n(RESET_N),
    .start(sym_start),
    .abort(state_ff != CWC_ST_SEND && !sym_start),
    .repeat_count(wake_pattern_repeat_count_ff),
    .drive_low(sym_drive),
    .in_idle(sym_idle),
    .done(sym_done)
  );

  // only the selected channel is ever enabled
  always_comb begin
    TX_ENABLE = 2'b00;
    TX_DATA = 2'b11;
    if (state_ff == CWC_ST_SEND && sym_drive) begin
      TX_ENABLE[ch] = 1'b1;
      TX_DATA[ch] = 1'b0;
    end
  end

  // sequence state machine
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CWC_ST_DEFAULT_CFG: begin
        if (cmd_valid_ff && cmd_ff == CWC_CMD_CONFIG) nxt_state = CWC_ST_CONFIG;
      end
      CWC_ST_CONFIG: begin
        if (cmd_valid_ff && cmd_ff == CWC_CMD_CONFIG_DONE) nxt_state = CWC_ST_READY;
      end
      CWC_ST_READY: begin
        if (cmd_wakeup && wake_pattern_repeat_count_ff >= CWC_REPEAT_MIN) begin
          nxt_state = CWC_ST_LISTEN;
        end else if (cmd_valid_ff && cmd_ff == CWC_CMD_CONFIG) begin
          nxt_state = CWC_ST_CONFIG;
        end else if (cmd_valid_ff && (cmd_ff == CWC_CMD_HALT_LATER ||
                     cmd_ff == CWC_CMD_FREEZE)) begin
          nxt_state = CWC_ST_HALT;
        end
      end
      CWC_ST_LISTEN: begin
        if (any_header || ch_pattern) nxt_state = CWC_ST_READY;
        else if (fast_expired || (noise_expired && !(&rx_active))) begin
          // fast timer expired, or noise timer expired with a channel quiet: start sending
          nxt_state = CWC_ST_SEND;
        end
      end
      CWC_ST_SEND: begin
        if (collision) nxt_state = CWC_ST_DETECT;
        else if (sym_done) nxt_state = CWC_ST_READY;
      end
      CWC_ST_DETECT: begin
        if (any_header || ch_pattern || fast_expired) nxt_state = CWC_ST_READY;
      end
      CWC_ST_HALT: begin
        if (cmd_valid_ff && cmd_ff == CWC_CMD_DEFAULT) nxt_state = CWC_ST_DEFAULT_CFG;
      end
      default: nxt_state = CWC_ST_DEFAULT_CFG;
    endcase
    if (in_wake && cmd_abort) begin
      nxt_state = (cmd_ff == CWC_CMD_HALT_LATER || cmd_ff == CWC_CMD_FREEZE) ?
                  CWC_ST_HALT : CWC_ST_READY;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      state_ff <= CWC_ST_DEFAULT_CFG;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // wakeup result
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      result_ff <= CWC_RES_NOT_SET;
    end else if (state_ff == CWC_ST_DEFAULT_CFG || cmd_wakeup) begin
      result_ff <= CWC_RES_NOT_SET;
    end else if (in_wake && !cmd_abort) begin
      unique case (state_ff)
        CWC_ST_LISTEN: begin
          if (any_header) result_ff <= CWC_RES_HEADER_HEARD;
          else if (ch_pattern) result_ff <= CWC_RES_PATTERN_HEARD;
        end
        CWC_ST_SEND: begin
          if (!collision && sym_done) result_ff <= CWC_RES_TRANSMITTED;
        end
        CWC_ST_DETECT: begin
          if (any_header) result_ff <= CWC_RES_CLASH_HEADER;
          else if (ch_pattern) result_ff <= CWC_RES_CLASH_PATTERN;
          else if (fast_expired) result_ff <= CWC_RES_CLASH_UNCLASSIFIED;
        end
        default: result_ff <= result_ff;
      endcase
    end
  end
endmodule : cwc_wakeup_ctrl
`default_nettype wire

// ==== tb/cwc_checker.sv ====
// Purpose: port checker for the cluster wakeup control block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module cwc_checker
  import cwc_pkg::*;
(
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // channels
  input wire logic [1:0] RX_ACTIVE,
  input wire logic [1:0] TX_DATA,
  input wire logic [1:0] TX_ENABLE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  logic rd_st_ff;
  logic [6:0] low_ff;
  // marks the data phase of a status read
  always_ff @(posedge MCLK) begin
    rd_st_ff <= RESET_N && HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[7:0] == CWC_OFF_STAT;
  end
  always_ff @(posedge MCLK) begin
    if (!RESET_N || TX_DATA == 2'b11) begin
      low_ff <= 7'h00;
    end else begin
      low_ff <= low_ff + 7'h01;
    end
  end
  chk_one_channel: assert property (TX_ENABLE != 2'b11)
    else $error("pattern enabled on both channels");
  chk_quiet_high: assert property ((TX_DATA | TX_ENABLE) == 2'b11)
    else $error("channel driven low without enable");
  chk_low_length: assert property (low_ff <= CWC_SYM_TX_CYC)
    else $error("driven part of symbol too long");
  chk_busy_no_send: assert property ((RX_ACTIVE == 2'b11) [*4] |-> !$rose(|TX_ENABLE))
    else $error("sending started on a busy bus");
  // window spans the point where the next driven part would have begun
  chk_clash_stops: assert property ($fell(|TX_ENABLE) ##1 (|RX_ACTIVE) [*4]
    |-> ##26 (TX_ENABLE == 2'b00) [*8]) else $error("idle activity did not stop sending");
  chk_send_low: assert property ($rose(|TX_ENABLE) |-> ##[0:2] (TX_DATA != 2'b11))
    else $error("send does not start with a driven part");
  chk_status_shape: assert property (rd_st_ff |-> $onehot(HRDATA[14:8])
    && HRDATA[7:3] == 5'h00 && HRDATA[2:0] <= 3'h6) else $error("bad status word");
  chk_pending_unset: assert property (rd_st_ff && (HRDATA[14:8] & 7'h38) != 7'h00
    |-> HRDATA[2:0] == 3'h0) else $error("result set while wakeup runs");
  chk_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");
  chk_reset_quiet: assert property (disable iff (1'b0) !RESET_N
    |=> TX_ENABLE == 2'b00 && TX_DATA == 2'b11) else $error("channel active after reset");
  cov_send_end: cover property ($fell(|TX_ENABLE));
  cov_unclassified: cover property (rd_st_ff && HRDATA[2:0] == 3'h5);
  cov_stuck: cover property ((RX_ACTIVE == 2'b11) [*8]);
endmodule : cwc_checker
bind cwc_wakeup_ctrl cwc_checker u_chk (.MCLK(MCLK), .RESET_N(RESET_N), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_ACTIVE(RX_ACTIVE), .TX_DATA(TX_DATA),
  .TX_ENABLE(TX_ENABLE));
`default_nettype wire

// ==== tb/cwc_node_model.sv ====
// Purpose: other nodes on both channels as seen by the receivers
// Assumes: bench asks for events by one-cycle requests
// Notes: events come after a bench-chosen lag and last four cycles
`timescale 1ns/100ps
`default_nettype none
module cwc_node_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // our transmitter on the wire
  input wire logic [1:0] tx_en,
  input wire logic [1:0] tx_data,
  // scenario controls
  input wire logic [1:0] busy,
  input wire logic clash,
  input wire logic [1:0] hdr_go,
  input wire logic [1:0] pat_go,
  input wire logic [3:0] lag,
  // receiver events
  output logic [1:0] rx_active,
  output logic [1:0] rx_header,
  output logic [1:0] rx_pattern
);
  logic [1:0] hdr_ff, pat_ff, out_h_ff, out_p_ff;
  logic [3:0] wait_ff;
  logic [2:0] len_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hdr_ff <= 2'h0;
      pat_ff <= 2'h0;
      out_h_ff <= 2'h0;
      out_p_ff <= 2'h0;
      wait_ff <= 4'h0;
      len_ff <= 3'h0;
    end else if ((hdr_go | pat_go) != 2'h0) begin
      hdr_ff <= hdr_go;
      pat_ff <= pat_go;
      wait_ff <= lag;
    end else if (wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
    end else if ((hdr_ff | pat_ff) != 2'h0) begin
      out_h_ff <= hdr_ff;
      out_p_ff <= pat_ff;
      hdr_ff <= 2'h0;
      pat_ff <= 2'h0;
      len_ff <= 3'h3;
    end else if (len_ff != 3'h0) begin
      len_ff <= len_ff - 3'h1;
    end else begin
      out_h_ff <= 2'h0;
      out_p_ff <= 2'h0;
    end
  end
  assign rx_header = out_h_ff;
  assign rx_pattern = out_p_ff;
  // own driven part loops back as activity, which the sender must ignore
  logic [1:0] last_en_ff;
  // remembers the channel we drove, so a clash falls into its idle gaps only
  always_ff @(posedge clk) begin
    if (!rst_n || !clash) begin
      last_en_ff <= 2'h0;
    end else if (tx_en != 2'h0) begin
      last_en_ff <= tx_en;
    end
  end
  assign rx_active = busy | (tx_en & ~tx_data) | (last_en_ff & ~tx_en & {2{clash}})
    | out_h_ff | out_p_ff;
endmodule : cwc_node_model
`default_nettype wire

// ==== tb/cluster_wakeup_control_tb.sv ====
// Purpose: self-checking bench for the cluster wakeup control block
// Assumes: short timers, one AHB-Lite master, node model on the channels
// Notes: reads note expectations; a monitor compares at the data phase of each checked read
`timescale 1ns/100ps
`default_nettype none
module cluster_wakeup_control_tb;
  import cwc_pkg::*;
  logic mclk, reset_n, hsel, hwrite, hready, hresp, clash, note, sel;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, tx_data, tx_en, rx_act, rx_hdr, rx_pat, busy, hdr_go, pat_go, chm;
  logic [3:0] lag, rep;
  logic [2:0] hsize;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] q_val[$];
  logic [31:0] q_msk[$];
  string q_nm[$];
  always #4 mclk = ~mclk;
  cwc_wakeup_ctrl #(.FAST_CYC(20), .NOISE_CYC(60)) DUT (.MCLK(mclk), .RESET_N(reset_n),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .RX_ACTIVE(rx_act), .RX_HEADER_OK(rx_hdr), .RX_PATTERN_OK(rx_pat), .TX_DATA(tx_data),
    .TX_ENABLE(tx_en));
  cwc_node_model NODE (.clk(mclk), .rst_n(reset_n), .tx_en(tx_en), .tx_data(tx_data),
    .busy(busy), .clash(clash), .hdr_go(hdr_go), .pat_go(pat_go), .lag(lag),
    .rx_active(rx_act), .rx_header(rx_hdr), .rx_pattern(rx_pat));
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    input logic ck, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    hwdata <= wd;
    note <= ck;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
    note <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 1'b0, r);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
    input string nm);
    logic [31:0] r;
    q_val.push_back(v);
    q_msk.push_back(m);
    q_nm.push_back(nm);
    bus(1'b0, a, $urandom, 1'b1, r);
  endtask : chk
  task automatic chk_st(input logic [6:0] s, input logic [2:0] res);
    chk(CWC_OFF_STAT, {17'h0, s, 5'h0, res}, 32'h7F07, "status");
  endtask : chk_st
  task automatic cmd(input logic [3:0] c);
    wr(CWC_OFF_CMD, {28'h0, c});
  endtask : cmd
  // polls the state field; gives up after a bounded number of reads
  task automatic wait_st(input logic [6:0] s);
    logic [31:0] r;
    int i;
    r = 32'h0;
    i = 0;
    while (r[14:8] !== s && i < 500) begin
      bus(1'b0, CWC_OFF_STAT, $urandom, 1'b0, r);
      i++;
    end
    compares++;
    if (r[14:8] !== s) begin
      n_errors++;
      $display("CHECK FAILED state wait expected %h seen %h", s, r[14:8]);
    end
  endtask : wait_st
  task automatic fire(input logic [1:0] h, input logic [1:0] p);
    hdr_go <= h;
    pat_go <= p;
    lag <= 4'(2 + $urandom % 6);
    @(posedge mclk);
    hdr_go <= 2'h0;
    pat_go <= 2'h0;
  endtask : fire
  task automatic setup(input logic [3:0] n);
    cmd(CWC_CMD_CONFIG);
    wait_st(CWC_ST_CONFIG);
    wr(CWC_OFF_CFG, {24'h0, n, 3'h0, sel});
    cmd(CWC_CMD_CONFIG_DONE);
    wait_st(CWC_ST_READY);
    wr(CWC_OFF_CFG, 32'h0);
    chk(CWC_OFF_CFG, {24'h0, n, 3'h0, sel}, 32'hFF, "cfg kept");
  endtask : setup
  always @(posedge mclk) begin
    if (note === 1'b1 && q_val.size() > 0) begin
      compares++;
      if ((hrdata & q_msk[0]) !== (q_val[0] & q_msk[0])) begin
        n_errors++;
        $display("CHECK FAILED %s expected %h seen %h", q_nm[0], q_val[0], hrdata);
      end
      q_val.delete(0);
      q_msk.delete(0);
      q_nm.delete(0);
    end
  end
  // cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    {hsel, hwrite, note, clash} = 4'h0;
    {haddr, hwdata, htrans, busy, hdr_go, pat_go, lag, hsize} = '0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    void'($urandom(32'h29f5));
    sel = 1'($urandom % 2);
    chm = sel ? 2'b10 : 2'b01;
    rep = 4'(2 + $urandom % 2);
    @(posedge mclk);
    chk_st(CWC_ST_DEFAULT_CFG, CWC_RES_NOT_SET);
    chk(CWC_OFF_CFG, 32'h20, 32'hFF, "cfg reset");
    chk(8'h10, 32'h0, 32'hFFFFFFFF, "unmapped");
    wr(CWC_OFF_CFG, 32'h31);
    chk(CWC_OFF_CFG, 32'h20, 32'hFF, "cfg locked");
    setup(rep);
    cmd(CWC_CMD_WAKEUP);
    repeat (2) @(posedge mclk);
    chk_st(CWC_ST_LISTEN, CWC_RES_NOT_SET);
    wait_st(CWC_ST_READY);
    chk_st(CWC_ST_READY, CWC_RES_TRANSMITTED);
    for (int k = 0; k < 2; k++) begin
      cmd(CWC_CMD_WAKEUP);
      fire(k == 0 ? 2'(1 + $urandom % 3) : 2'h0, k == 1 ? chm : 2'h0);
      wait_st(CWC_ST_READY);
      chk_st(CWC_ST_READY, k == 0 ? CWC_RES_HEADER_HEARD : CWC_RES_PATTERN_HEARD);
    end
    for (int k = 0; k < 3; k++) begin
      clash <= 1'b1;
      cmd(CWC_CMD_WAKEUP);
      while (tx_en == 2'b00) @(posedge mclk);
      while (tx_en != 2'b00) @(posedge mclk);
      repeat (4) @(posedge mclk);
      clash <= 1'b0;
      fire(k == 0 ? chm : 2'h0, k == 1 ? chm : 2'h0);
      wait_st(CWC_ST_READY);
      chk_st(CWC_ST_READY, CWC_RES_CLASH_HEADER + 3'(k));
    end
    for (int k = 0; k < 4; k++) begin
      busy <= 2'b11;
      cmd(CWC_CMD_WAKEUP);
      repeat (200) @(posedge mclk);
      chk_st(CWC_ST_LISTEN, CWC_RES_NOT_SET);
      cmd(CWC_CMD_READY_NOW + 4'(k));
      busy <= 2'b00;
      wait_st(k < 2 ? CWC_ST_READY : CWC_ST_HALT);
      chk_st(k < 2 ? CWC_ST_READY : CWC_ST_HALT, CWC_RES_NOT_SET);
      if (k > 1) begin
        cmd(CWC_CMD_DEFAULT);
        wait_st(CWC_ST_DEFAULT_CFG);
        setup(rep);
      end
    end
    cmd(CWC_CMD_FREEZE);
    cmd(CWC_CMD_DEFAULT);
    wait_st(CWC_ST_DEFAULT_CFG);
    setup(4'($urandom % 2));
    cmd(CWC_CMD_WAKEUP);
    repeat (40) @(posedge mclk);
    chk_st(CWC_ST_READY, CWC_RES_NOT_SET);
    close_out();
  end
endmodule : cluster_wakeup_control_tb
`default_nettype wire
